// ==== src/homing_map.vh ====
// Offsets, field positions, reset values and timing counts of the homing block
`ifndef HOMING_MAP_VH
`define HOMING_MAP_VH

// Register byte offsets
`define REG_CTRL            12'h000
`define REG_HOME_SPEED      12'h004
`define REG_CREEP_SPEED     12'h008
`define REG_HOME_METHOD     12'h00C
`define REG_DISP_PARAM      12'h010
`define REG_FEED_MULT       12'h014
`define REG_PT1_ACCDEC      12'h018
`define REG_POS_RANGE_LO    12'h01C
`define REG_POS_RANGE_HI    12'h020
`define REG_STATUS          12'h024
`define REG_CUR_POS         12'h028
`define REG_CMD_POS         12'h02C
`define REG_WARN_CODE       12'h030
`define REG_DISP_CUR        12'h034
`define REG_DISP_CMD        12'h038

// Control register bits
`define CTRL_ABS_SYS        0
`define CTRL_UNIT_DEG       1
`define CTRL_INCR_CMD       2
`define CTRL_WARN_CLR       3

// Homing method field: bit 4 is the homing direction (1 = reverse)
`define METHOD_DIR_BIT      4

// Position display field positions
`define DISP_FRAC_BIT       0
`define DISP_SEL_LSB        4
`define DISP_SEL_MSB        7
`define DISP_SEL_ROLL       4'h1

// Warning codes, tenths of the printed code
`define WARN_NONE           16'h0000
`define WARN_HOME_INCOMP    16'h0384
`define WARN_HOME_NOTDONE   16'h0385

// Reset values
`define RST_HOME_SPEED      32'h0000_01F4
`define RST_CREEP_SPEED     32'h0000_000A
`define RST_POS_RANGE_LO    32'hFFF0_BDC1
`define RST_POS_RANGE_HI    32'h000F_423F

// Stop settle time after a dog pass, ns, and its cycle count
`define STOP_SETTLE_NS      1000
`define CLK_PERIOD_NS       4
`define STOP_SETTLE_CYC     ((`STOP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== src/input_sync.v ====
// Two-stage synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none

module input_sync #(
    parameter WIDTH = 9
) (
    // Clock and reset
    input  wire             clk_sys,
    input  wire             rst,
    // Data
    input  wire [WIDTH-1:0] d_in,
    output wire [WIDTH-1:0] d_out
);

    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;

    // ************************************************************
    // Per-bit two-flop chain
    // ************************************************************
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            // First stage feeds only the second
            always @(posedge clk_sys)
            begin
                if (rst)
                begin
                    meta_ff[i] <= 1'b0;
                    sync_ff[i] <= 1'b0;
                end
                else
                begin
                    meta_ff[i] <= d_in[i];
                    sync_ff[i] <= meta_ff[i];
                end
            end
        end
    endgenerate

    assign d_out = sync_ff;

endmodule

`default_nettype wire

// ==== src/homing_seq.v ====
// Homing retract, automatic return to home and roll feed display sequencer
`timescale 1ns/1ps
`default_nettype none
`include "homing_map.vh"

module homing_seq #(
    parameter POS_W = 32
) (
    // Clock and reset
    input  wire             clk_sys,
    input  wire             rst,
    // APB slave
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [11:0]      paddr,
    input  wire [31:0]      pwdata,
    output reg  [31:0]      prdata,
    output reg              pready,
    output reg              pslverr,
    // Controller discrete inputs (asynchronous pins)
    input  wire             op_mode_select_1,
    input  wire [4:0]       table_select,
    input  wire             forward_start_input,
    input  wire             reverse_start_input,
    // Sensor pins, active high when asserted
    input  wire             fwd_stroke_limit,
    input  wire             rev_stroke_limit,
    input  wire             proximity_dog,
    // Motion core handshake (same clock)
    input  wire             home_found,
    input  wire             move_done,
    input  wire [POS_W-1:0] cur_pos,
    input  wire [POS_W-1:0] cmd_pos,
    // Motion commands
    output reg              move_en,
    output reg              move_dir_rev,
    output reg  [31:0]      move_speed,
    output reg  [31:0]      move_accdec,
    output reg              move_to_home,
    output reg              frac_clear,
    output reg              homing_active,
    output reg              homing_incomplete_warning,
    output reg              homing_not_done_warning,
    output reg              home_valid
);

    // ************************************************************
    // Pin synchronisation
    // ************************************************************
    wire [8:0] pins_sync;

    input_sync #(
        .WIDTH (9)
    ) u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .d_in    ({op_mode_select_1, table_select, reverse_start_input,
                   fwd_stroke_limit, rev_stroke_limit}),
        .d_out   (pins_sync)
    );

    wire       mode_s  = pins_sync[8];
    wire [4:0] table_s = pins_sync[7:3];
    wire       rst2_s  = pins_sync[2];
    wire       lsp_s   = pins_sync[1];
    wire       lsn_s   = pins_sync[0];

    reg [1:0] st_sync_ff;
    reg [1:0] dog_sync_ff;
    wire      st1_s = st_sync_ff[1];
    wire      dog_s = dog_sync_ff[1];

    // Remaining pins, same two-flop scheme
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            st_sync_ff  <= 2'h0;
            dog_sync_ff <= 2'h0;
        end
        else
        begin
            st_sync_ff  <= {st_sync_ff[0], forward_start_input};
            dog_sync_ff <= {dog_sync_ff[0], proximity_dog};
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    reg [3:0]       ctrl_ff;
    reg [31:0]      home_speed_ff;
    reg [31:0]      creep_speed_ff;
    reg [7:0]       method_ff;
    reg [7:0]       disp_ff;
    reg [1:0]       feed_mult_ff;
    reg [31:0]      accdec_ff;
    reg [31:0]      range_lo_ff;
    reg [31:0]      range_hi_ff;
    reg [POS_W-1:0] disp_base_cur_ff;
    reg [POS_W-1:0] disp_base_cmd_ff;
    reg             rst2_d_ff;
    reg             st1_d_ff;
    reg [15:0]      warn_code_ff;

    wire apb_wr = psel & penable & pwrite & pready;
    wire apb_rd_setup = psel & ~penable & ~pwrite;

    // Homing mode selection: mode select on, all table bits off
    wire homing_mode = mode_s & (table_s == 5'h00);
    wire unit_deg    = ctrl_ff[`CTRL_UNIT_DEG];
    wire dir_rev     = method_ff[`METHOD_DIR_BIT];
    wire roll_on     = (disp_ff[`DISP_SEL_MSB:`DISP_SEL_LSB] == `DISP_SEL_ROLL)
                       & ~unit_deg;
    // Roll feed needs the incremental command system
    wire roll_valid  = roll_on & ctrl_ff[`CTRL_INCR_CMD];
    wire in_range    = ($signed(cur_pos) >= $signed(range_lo_ff)) &
                       ($signed(cur_pos) <= $signed(range_hi_ff));
    wire home_start  = homing_mode & st1_s & ~st1_d_ff;
    wire ret_start   = homing_mode & rst2_s & ~rst2_d_ff;
    wire any_start   = (st1_s & ~st1_d_ff) | (rst2_s & ~rst2_d_ff);

    // ************************************************************
    // Sequencer
    // ************************************************************
    localparam [3:0] S_IDLE    = 4'h0;
    localparam [3:0] S_SEARCH  = 4'h1;
    localparam [3:0] S_CREEP   = 4'h2;
    localparam [3:0] S_OFFDOG  = 4'h3;
    localparam [3:0] S_TO_LIM  = 4'h4;
    localparam [3:0] S_BACK    = 4'h5;
    localparam [3:0] S_PASSED  = 4'h6;
    localparam [3:0] S_SETTLE  = 4'h7;
    localparam [3:0] S_RETURN  = 4'h8;

    reg [3:0]  state_ff;
    reg [3:0]  nxt_state;
    reg [15:0] settle_ff;
    reg        seen_dog_ff;
    // Sized once here so the load below keeps its width
    localparam [15:0] SETTLE_LOAD = `STOP_SETTLE_CYC;

    // Limit in the current travel direction; soft limits never used here
    wire lim_ahead = move_dir_rev ? lsn_s : lsp_s;
    wire lim_far   = move_dir_rev ? lsn_s : lsp_s;

    // Next-state selection
    always @*
    begin
        nxt_state = state_ff;
        case (state_ff)
            S_IDLE:
            begin
                if (home_start)
                begin
                    if (dog_s)
                        nxt_state = S_OFFDOG;
                    else
                        nxt_state = S_SEARCH;
                end
                else if (ret_start && home_valid && in_range)
                    nxt_state = S_RETURN;
            end
            S_SEARCH:
            begin
                if (dog_s)
                    nxt_state = S_CREEP;
                else if (lim_ahead)
                    nxt_state = S_BACK;
            end
            S_CREEP:
            begin
                if (home_found)
                    nxt_state = S_IDLE;
            end
            S_OFFDOG:
            begin
                if (!dog_s)
                    nxt_state = S_SETTLE;
            end
            S_BACK:
            begin
                if (dog_s)
                    nxt_state = S_PASSED;
                else if (lim_far)
                    nxt_state = S_IDLE;
            end
            S_PASSED:
            begin
                if (!dog_s)
                    nxt_state = S_SETTLE;
            end
            S_SETTLE:
            begin
                if (settle_ff == 16'h0000)
                    nxt_state = S_SEARCH;
            end
            S_RETURN:
            begin
                if (move_done)
                    nxt_state = S_IDLE;
            end
            default:
                nxt_state = S_IDLE;
        endcase
    end

    // State, motion outputs and warnings
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_ff                  <= S_IDLE;
            settle_ff                 <= 16'h0000;
            seen_dog_ff               <= 1'b0;
            move_en                   <= 1'b0;
            move_dir_rev              <= 1'b0;
            move_speed                <= 32'h0000_0000;
            move_accdec               <= 32'h0000_0000;
            move_to_home              <= 1'b0;
            frac_clear                <= 1'b0;
            homing_active             <= 1'b0;
            homing_incomplete_warning <= 1'b0;
            homing_not_done_warning   <= 1'b0;
            home_valid                <= 1'b0;
            warn_code_ff              <= `WARN_NONE;
            st1_d_ff                  <= 1'b0;
            rst2_d_ff                 <= 1'b0;
        end
        else
        begin
            state_ff  <= nxt_state;
            st1_d_ff  <= st1_s;
            rst2_d_ff <= rst2_s;
            // Absolute system keeps home established from the cycle after its control bit is set
            if (ctrl_ff[`CTRL_ABS_SYS])
                home_valid <= 1'b1;
            else if (state_ff == S_CREEP && home_found)
                home_valid <= 1'b1;
            // Fraction clear pulse at any operation start
            frac_clear <= any_start & disp_ff[`DISP_FRAC_BIT];
            // Warnings: set beats software clear
            if (state_ff == S_BACK && lim_far && !dog_s)
            begin
                homing_incomplete_warning <= 1'b1;
                warn_code_ff              <= `WARN_HOME_INCOMP;
            end
            else if (state_ff == S_IDLE && ret_start && !home_valid)
            begin
                homing_not_done_warning <= 1'b1;
                warn_code_ff            <= `WARN_HOME_NOTDONE;
            end
            else if (apb_wr && paddr == `REG_CTRL && pwdata[`CTRL_WARN_CLR])
            begin
                homing_incomplete_warning <= 1'b0;
                homing_not_done_warning   <= 1'b0;
                warn_code_ff              <= `WARN_NONE;
            end
            // Settle counter loads on every dog pass
            if (nxt_state == S_SETTLE && state_ff != S_SETTLE)
                settle_ff <= SETTLE_LOAD;
            else if (settle_ff != 16'h0000)
                settle_ff <= settle_ff - 16'h0001;
            if (state_ff == S_SEARCH)
                seen_dog_ff <= 1'b0;
            else if (dog_s)
                seen_dog_ff <= 1'b1;
            // Drive motion per next state
            homing_active <= (nxt_state != S_IDLE) && (nxt_state != S_RETURN);
            move_to_home  <= (nxt_state == S_RETURN);
            move_en <= (nxt_state != S_IDLE) && (nxt_state != S_SETTLE);
            move_accdec <= accdec_ff;
            case (nxt_state)
                S_SEARCH:
                begin
                    move_dir_rev <= dir_rev;
                    move_speed   <= home_speed_ff;
                end
                S_CREEP:
                    move_speed <= creep_speed_ff;
                S_OFFDOG, S_BACK:
                begin
                    move_dir_rev <= ~dir_rev;
                    move_speed   <= home_speed_ff;
                end
                S_RETURN:
                begin
                    move_speed <= home_speed_ff;
                    // Linear units head straight back toward zero
                    if (unit_deg)
                        move_dir_rev <= dir_rev;
                    else
                        move_dir_rev <= ~cur_pos[POS_W-1] & (cur_pos != 0);
                end
                default:
                    move_speed <= move_speed;
            endcase
        end
    end

    // ************************************************************
    // Roll feed display base: display only, motion untouched
    // ************************************************************
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            disp_base_cur_ff <= {POS_W{1'b0}};
            disp_base_cmd_ff <= {POS_W{1'b0}};
        end
        else if (any_start && roll_valid)
        begin
            disp_base_cur_ff <= cur_pos;
            disp_base_cmd_ff <= cmd_pos;
        end
    end

    wire [POS_W-1:0] disp_cur = roll_valid ? cur_pos - disp_base_cur_ff : cur_pos;
    wire [POS_W-1:0] disp_cmd = roll_valid ? cmd_pos - disp_base_cmd_ff : cmd_pos;

    // ************************************************************
    // APB slave, no wait states, unmapped address answers error
    // ************************************************************
    reg        mapped;
    reg [31:0] rd_mux;

    always @*
    begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            `REG_CTRL:         rd_mux = {28'h0000000, ctrl_ff};
            `REG_HOME_SPEED:   rd_mux = home_speed_ff;
            `REG_CREEP_SPEED:  rd_mux = creep_speed_ff;
            `REG_HOME_METHOD:  rd_mux = {24'h000000, method_ff};
            `REG_DISP_PARAM:   rd_mux = {24'h000000, disp_ff};
            `REG_FEED_MULT:    rd_mux = {30'h00000000, feed_mult_ff};
            `REG_PT1_ACCDEC:   rd_mux = accdec_ff;
            `REG_POS_RANGE_LO: rd_mux = range_lo_ff;
            `REG_POS_RANGE_HI: rd_mux = range_hi_ff;
            `REG_STATUS:       rd_mux = {24'h000000, roll_valid, state_ff,
                                         homing_not_done_warning,
                                         homing_incomplete_warning, home_valid};
            `REG_CUR_POS:      rd_mux = cur_pos[31:0];
            `REG_CMD_POS:      rd_mux = cmd_pos[31:0];
            `REG_WARN_CODE:    rd_mux = {16'h0000, warn_code_ff};
            `REG_DISP_CUR:     rd_mux = disp_cur[31:0];
            `REG_DISP_CMD:     rd_mux = disp_cmd[31:0];
            default:           mapped = 1'b0;
        endcase
    end

    // Ready in the first access cycle; writes land at that edge
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            pready         <= 1'b0;
            pslverr        <= 1'b0;
            prdata         <= 32'h0000_0000;
            ctrl_ff        <= 4'h0;
            home_speed_ff  <= `RST_HOME_SPEED;
            creep_speed_ff <= `RST_CREEP_SPEED;
            method_ff      <= 8'h00;
            disp_ff        <= 8'h00;
            feed_mult_ff   <= 2'h0;
            accdec_ff      <= 32'h0000_0000;
            range_lo_ff    <= `RST_POS_RANGE_LO;
            range_hi_ff    <= `RST_POS_RANGE_HI;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            if (apb_rd_setup)
                prdata <= rd_mux;
            if (apb_wr && mapped)
            begin
                case (paddr)
                    `REG_CTRL:         ctrl_ff        <= {1'b0, pwdata[2:0]};
                    `REG_HOME_SPEED:   home_speed_ff  <= pwdata;
                    `REG_CREEP_SPEED:  creep_speed_ff <= pwdata;
                    `REG_HOME_METHOD:  method_ff      <= pwdata[7:0];
                    `REG_DISP_PARAM:   disp_ff        <= pwdata[7:0];
                    `REG_FEED_MULT:    feed_mult_ff   <= pwdata[1:0];
                    `REG_PT1_ACCDEC:   accdec_ff      <= pwdata;
                    `REG_POS_RANGE_LO: range_lo_ff    <= pwdata;
                    `REG_POS_RANGE_HI: range_hi_ff    <= pwdata;
                    default:           ctrl_ff        <= ctrl_ff;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// ==== tb/ctrl_model.sv ====
// Positioning controller model driving the mode and start pins
`timescale 1ns/1ps
`default_nettype none

module ctrl_model (
    // Clock and reset
    input  wire logic  clk_sys,
    input  wire logic  rst,
    // Request from the bench
    input  wire logic  req,
    input  wire logic  fwd,
    // Discrete pins
    output logic       op_mode_select_1,
    output logic [4:0] table_select,
    output logic       forward_start_input,
    output logic       reverse_start_input
);
    logic [3:0] cnt_ff;

    // Frame counter; busy frames ignore new requests
    always @(posedge clk_sys)
    begin
        if (rst)
            cnt_ff <= 4'h0;
        else if (req && cnt_ff == 4'h0)
            cnt_ff <= 4'hC;
        else if (cnt_ff != 4'h0)
            cnt_ff <= cnt_ff - 4'h1;
    end

    // Mode settles first so it is stable when start rises
    assign op_mode_select_1    = (cnt_ff != 4'h0);
    assign table_select        = 5'h00;
    // Forward start begins a homing, reverse start the fast return
    assign forward_start_input = fwd && (cnt_ff != 4'h0) && (cnt_ff < 4'h9);
    assign reverse_start_input = !fwd && (cnt_ff != 4'h0) && (cnt_ff < 4'h9);
endmodule

`default_nettype wire

// ==== tb/homing_seq_monitor.sv ====
// Assertion checker for the homing sequencer ports
`timescale 1ns/1ps
`default_nettype none
`include "homing_map.vh"

module homing_seq_monitor (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // Motion and status
    input  wire logic        move_done,
    input  wire logic        move_en,
    input  wire logic [31:0] move_speed,
    input  wire logic [31:0] move_accdec,
    input  wire logic        move_to_home,
    input  wire logic        frac_clear,
    input  wire logic        homing_incomplete_warning,
    input  wire logic        homing_not_done_warning,
    input  wire logic        home_valid
);
    logic [31:0] spd_ff;
    logic [31:0] acc_ff;
    logic        wr_go;
    logic        clr_go;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Shadow words so checks use what software wrote
    assign wr_go  = psel && penable && pready && pwrite && !pslverr;
    assign clr_go = wr_go && paddr == `REG_CTRL && pwdata[`CTRL_WARN_CLR];
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            spd_ff <= `RST_HOME_SPEED;
            acc_ff <= 32'h0;
        end
        else if (wr_go && paddr == `REG_HOME_SPEED)
            spd_ff <= pwdata;
        else if (wr_go && paddr == `REG_PT1_ACCDEC)
            acc_ff <= pwdata;
    end

    property p_nd_still; $rose(homing_not_done_warning) |-> !move_en; endproperty
    a_nd_still: assert property (p_nd_still) else $error("moved when refused");
    property p_nd_sticky; homing_not_done_warning && !clr_go |=> homing_not_done_warning;
    endproperty
    a_nd_sticky: assert property (p_nd_sticky) else $error("warning lost");
    property p_ret_ok; $rose(move_to_home) |-> move_en && home_valid; endproperty
    a_ret_ok: assert property (p_ret_ok) else $error("return without home");
    property p_speed; move_to_home && move_en |-> move_speed == spd_ff; endproperty
    a_speed: assert property (p_speed) else $error("return speed wrong");
    property p_ramp; move_to_home && move_en |-> move_accdec == acc_ff; endproperty
    a_ramp: assert property (p_ramp) else $error("return ramp wrong");
    property p_frac; frac_clear |=> !frac_clear; endproperty
    a_frac: assert property (p_frac) else $error("fraction clear too long");
    property p_done; move_to_home && move_done |=> !move_en; endproperty
    a_done: assert property (p_done) else $error("no stop after done");
    property p_inc_stop; $rose(homing_incomplete_warning) |-> ##[0:2] !move_en; endproperty
    a_inc_stop: assert property (p_inc_stop) else $error("no stop on warning");
    property p_rdy; pready |=> !pready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready held");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");

    // Main scenarios
    c_ret: cover property (move_to_home && move_done);
    c_nd: cover property ($rose(homing_not_done_warning));
    c_frac: cover property (frac_clear);
    c_err: cover property (pslverr);
endmodule

`default_nettype wire

// ==== tb/test_homing_seq.sv ====
// Self-checking bench for the homing sequencer
`timescale 1ns/1ps
`default_nettype none
`include "homing_map.vh"

module test_homing_seq;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        req = 1'b0;
    logic        fwd = 1'b0;
    logic        move_done = 1'b0;
    logic        home_found = 1'b0;
    logic        fwd_stroke_limit = 1'b0;
    logic        rev_stroke_limit = 1'b0;
    logic        proximity_dog = 1'b0;
    logic [31:0] cur_pos = 32'h0;
    logic [31:0] cmd_pos = 32'h0;
    logic [31:0] q, spd, acc;
    logic        er, fc_seen;
    integer      err_total = 0;
    integer      compares = 0;
    wire  [31:0] prdata, move_speed, move_accdec;
    wire  [4:0]  table_select;
    wire         pready, pslverr, op_mode_select_1, forward_start_input, reverse_start_input;
    wire         move_en, move_dir_rev, move_to_home, frac_clear, homing_active;
    wire         homing_incomplete_warning, homing_not_done_warning, home_valid;

    // Clock 250 MHz
    always #2 clk_sys = ~clk_sys;

    ctrl_model u_ctrl (.clk_sys(clk_sys), .rst(rst), .req(req), .fwd(fwd),
        .op_mode_select_1(op_mode_select_1), .table_select(table_select),
        .forward_start_input(forward_start_input), .reverse_start_input(reverse_start_input));

    homing_seq u_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .op_mode_select_1(op_mode_select_1), .table_select(table_select),
        .forward_start_input(forward_start_input), .reverse_start_input(reverse_start_input),
        .fwd_stroke_limit(fwd_stroke_limit), .rev_stroke_limit(rev_stroke_limit),
        .proximity_dog(proximity_dog), .home_found(home_found), .move_done(move_done),
        .cur_pos(cur_pos), .cmd_pos(cmd_pos), .move_en(move_en), .move_dir_rev(move_dir_rev),
        .move_speed(move_speed), .move_accdec(move_accdec), .move_to_home(move_to_home),
        .frac_clear(frac_clear), .homing_active(homing_active),
        .homing_incomplete_warning(homing_incomplete_warning),
        .homing_not_done_warning(homing_not_done_warning), .home_valid(home_valid));

    task summarize;
    begin
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        compares = compares + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask

    // One APB transfer, held until pready is sampled high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        integer n;
    begin
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n = n + 1;
        end
        while (pready !== 1'b1 && n < 20);
        q = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            err_total = err_total + 1;
            summarize;
        end
    end
    endtask

    // Start request, spaced so the controller frame has ended
    task kick_wait;
        integer n;
    begin
        repeat (16) @(posedge clk_sys);
        req <= 1'b1;
        @(posedge clk_sys);
        req <= 1'b0;
        fc_seen = 1'b0;
        for (n = 0; n < 40 && move_en !== 1'b1; n = n + 1)
        begin
            @(posedge clk_sys);
            if (frac_clear === 1'b1)
                fc_seen = 1'b1;
        end
    end
    endtask

    // Main sequence
    initial
    begin
        spd = $urandom(32'h87DD0D94);
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk({31'h0, home_valid}, 32'h0);
        apb(1'b0, 12'h03C, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(q, 32'h0);
        apb(1'b0, `REG_HOME_SPEED, 32'h0);
        chk(q, `RST_HOME_SPEED);
        spd = $urandom;
        acc = $urandom;
        apb(1'b1, `REG_HOME_SPEED, spd);
        apb(1'b1, `REG_PT1_ACCDEC, acc);
        apb(1'b0, `REG_HOME_SPEED, 32'h0);
        chk(q, spd);
        cur_pos <= 32'h1 + ($urandom % 32'd999);
        kick_wait;
        chk({31'h0, move_en}, 32'h0);
        chk({31'h0, homing_not_done_warning}, 32'h1);
        apb(1'b0, `REG_WARN_CODE, 32'h0);
        chk(q, {16'h0, `WARN_HOME_NOTDONE});
        apb(1'b1, `REG_DISP_PARAM, 32'h11);
        apb(1'b1, `REG_CTRL, 32'hD);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, home_valid}, 32'h1);
        chk({31'h0, homing_not_done_warning}, 32'h0);
        kick_wait;
        chk({31'h0, move_to_home}, 32'h1);
        chk(move_speed, spd);
        chk(move_accdec, acc);
        chk({31'h0, fc_seen}, 32'h1);
        apb(1'b0, `REG_DISP_CUR, 32'h0);
        chk(q, 32'h0);
        move_done <= 1'b1;
        @(posedge clk_sys);
        move_done <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk({31'h0, move_en}, 32'h0);
        // Degree unit must drop the roll display
        apb(1'b1, `REG_CTRL, 32'h7);
        apb(1'b0, `REG_DISP_CUR, 32'h0);
        chk(q, cur_pos);
        apb(1'b1, `REG_POS_RANGE_HI, 32'h0);
        kick_wait;
        chk({31'h0, move_en}, 32'h0);
        chk({31'h0, homing_not_done_warning}, 32'h0);
        // Homing started on the dog backs off it first
        fwd <= 1'b1;
        proximity_dog <= 1'b1;
        kick_wait;
        chk({31'h0, move_dir_rev}, 32'h1);
        summarize;
    end
endmodule

bind homing_seq homing_seq_monitor u_mon (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .move_done(move_done), .move_en(move_en), .move_speed(move_speed),
    .move_accdec(move_accdec), .move_to_home(move_to_home), .frac_clear(frac_clear),
    .homing_incomplete_warning(homing_incomplete_warning),
    .homing_not_done_warning(homing_not_done_warning), .home_valid(home_valid));

`default_nettype wire
